// ### rtl/dioc_consts.svh
`ifndef DIOC_CONSTS_SVH
`define DIOC_CONSTS_SVH

// Register byte offsets in the configuration space.
`define DIOC_OFS_CAL_LO 8'h8c
`define DIOC_OFS_CAL_HI 8'h8d
`define DIOC_OFS_PAT 8'h8e
`define DIOC_OFS_CLK 8'h90
`define DIOC_OFS_PH0 8'h91
`define DIOC_OFS_PH1 8'h92
`define DIOC_OFS_CS_LO 8'h93
`define DIOC_OFS_CS_HI 8'h94
`define DIOC_OFS_CMD_LO 8'h95
`define DIOC_OFS_CMD_HI 8'h96

// Field positions inside the calibration control byte and clock byte.
`define DIOC_BIT_RTRIG 0
`define DIOC_BIT_WTRIG 1
`define DIOC_BIT_MASK 2
`define DIOC_BIT_PLLDIV 5

// Frequency codes: the reset code and the legal window.
`define DIOC_FREQ_PLL_RST 4'hf
`define DIOC_FREQ_MIN 4'h4
`define DIOC_FREQ_MAX 4'h7

// Sequence sizes: eight bursts, eight quadwords each.
`define DIOC_BURSTS 4'h8
`define DIOC_LAST_IDX 3'h7
`define DIOC_EVEN_STEP 4

// Byte mask values and fixed read leveling patterns.
`define DIOC_MASK_ALL 8'hff
`define DIOC_MASK_NONE 8'h00
`define DIOC_LVL_01 64'h0100_0100_0100_0100
`define DIOC_LVL_FF 64'hff00_ff00_ff00_ff00
`define DIOC_ZERO_LOW 20'h0_0000

`endif

// ### rtl/dioc_pkg.sv
package dioc_pkg;

  typedef enum logic [1:0] {
    DIOC_IDLE = 2'b00,
    DIOC_REQ = 2'b01,
    DIOC_WBEAT = 2'b10,
    DIOC_RBEAT = 2'b11
  } dioc_state_t;

  typedef struct packed {
    logic [7:0] pat;
    logic [11:0] cal_addr;
    logic mask_sel;
    logic wtrig;
    logic rtrig;
    logic [3:0] freq;
    logic pll_div;
    logic [4:0] ph0;
    logic [4:0] ph1;
    logic [4:0] ph_cs;
    logic [4:0] ph_cmd;
  } dioc_regs_t;

  typedef struct packed {
    dioc_regs_t regs;
    dioc_state_t state;
    logic is_wr;
    logic [2:0] burst;
    logic [2:0] beat;
    logic wpend;
    logic rpend;
    logic mismatch;
    logic [7:0] rdata;
  } dioc_top_st_t;

  typedef struct packed {
    logic [7:0] even;
    logic [63:0] qw;
  } dioc_gen_st_t;

endpackage : dioc_pkg

// ### rtl/dioc_pat_if.sv
`timescale 1ns/1ps
// Carries pattern generator control and the current quadword.
interface dioc_pat_if;
  logic load;
  logic advance;
  logic level_mode;
  logic level_sel;
  logic [7:0] seed;
  logic [63:0] qw;
  modport gen (input load, input advance, input level_mode, input level_sel, input seed,
               output qw);
  modport user (output load, output advance, output level_mode, output level_sel,
                output seed, input qw);
endinterface : dioc_pat_if

// ### rtl/dioc_pattern_gen.sv
`timescale 1ns/1ps
`include "dioc_consts.svh"
module dioc_pattern_gen
  import dioc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  dioc_pat_if.gen pat
);

  dioc_gen_st_t st_ff;
  dioc_gen_st_t nxt_st;

  // Expands one even byte into four byte pairs; each pair shifts once more.
  function automatic logic [63:0] dioc_expand(input logic [7:0] even);
    logic [63:0] qw;
    qw = '0;
    for (int j = 0; j < 4; j++) begin
      qw[16*j +: 8] = even >> j;
      qw[16*j+8 +: 8] = ~(even >> j);
    end
    return qw;
  endfunction : dioc_expand

  // A load restarts from the seed; an advance continues the shifting chain.
  always_comb begin
    logic [7:0] base;
    base = pat.load ? pat.seed : st_ff.even;
    nxt_st = st_ff;
    if (pat.load || pat.advance) begin
      if (pat.level_mode) begin
        nxt_st.qw = pat.level_sel ? `DIOC_LVL_01 : `DIOC_LVL_FF;
      end else begin
        nxt_st.qw = dioc_expand(base);
      end
      nxt_st.even = base >> `DIOC_EVEN_STEP;
    end
  end

  // The whole state is registered at once.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pat.qw = st_ff.qw;

endmodule : dioc_pattern_gen

// ### rtl/dioc_phase_delay.sv
`timescale 1ns/1ps
module dioc_phase_delay #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  input wire logic [4:0] phase_in,
  output logic [W-1:0] q_out,
  output logic [4:0] tap_out
);

  typedef struct packed {
    logic [W-1:0] q;
    logic [4:0] tap;
  } dioc_phase_st_t;

  dioc_phase_st_t st_ff;
  dioc_phase_st_t nxt_st;

  // Retimes the group to the core clock; the tap picks the pad delay in 1/32 steps.
  always_comb begin
    nxt_st.q = d_in;
    nxt_st.tap = phase_in;
  end

  // Register stage shared by the whole output group.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_ff <= {RST_VAL, 5'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_out = st_ff.q;
  assign tap_out = st_ff.tap;

endmodule : dioc_phase_delay

// ### rtl/dioc_top.sv
`timescale 1ns/1ps
`include "dioc_consts.svh"
module dioc_top
  import dioc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out,
  output logic cal_req_valid_out,
  output logic cal_req_write_out,
  output logic [31:0] cal_req_addr_out,
  input wire logic cal_req_ready_in,
  output logic cal_wvalid_out,
  output logic [63:0] cal_wdata_out,
  output logic [7:0] byte_mask_out,
  input wire logic cal_wready_in,
  input wire logic cal_rvalid_in,
  input wire logic [63:0] cal_rdata_in,
  input wire logic read_level_mode_in,
  input wire logic read_level_sel_in,
  output logic cal_busy_out,
  output logic cal_mismatch_out,
  output logic [3:0] pll_freq_code_out,
  output logic pll_reset_out,
  output logic pll_vco_div2_out,
  output logic freq_illegal_out,
  input wire logic mclk_run_in,
  input wire logic [3:0] core_rank_select_n_in,
  input wire logic [3:0] core_cke_in,
  input wire logic core_row_strobe_n_in,
  input wire logic core_column_strobe_n_in,
  input wire logic core_write_enable_n_in,
  input wire logic [15:0] core_address_in,
  input wire logic [2:0] core_bank_in,
  output logic [5:0] memory_clock_out,
  output logic [4:0] mclk0_tap_out,
  output logic [4:0] mclk1_tap_out,
  output logic [3:0] rank_select_n_out,
  output logic [3:0] rank_clock_enable_out,
  output logic [4:0] rank_tap_out,
  output logic row_strobe_n_out,
  output logic column_strobe_n_out,
  output logic write_enable_n_out,
  output logic [15:0] memory_address_out,
  output logic [2:0] bank_address_out,
  output logic [4:0] cmd_tap_out
);

  dioc_top_st_t st_ff;
  dioc_top_st_t nxt_st;
  dioc_pat_if pat_bus ();
  logic wr_beat_take;
  logic rd_beat_take;

  // Handshake completions that move the sequence forward.
  assign wr_beat_take = (st_ff.state == DIOC_WBEAT) && cal_wready_in;
  assign rd_beat_take = (st_ff.state == DIOC_RBEAT) && cal_rvalid_in;

  // Pattern generator is reloaded per burst and stepped per quadword.
  assign pat_bus.load = (st_ff.state == DIOC_REQ) && cal_req_ready_in;
  assign pat_bus.advance = wr_beat_take || rd_beat_take;
  assign pat_bus.seed = st_ff.regs.pat;
  assign pat_bus.level_mode = read_level_mode_in && !st_ff.is_wr;
  assign pat_bus.level_sel = read_level_sel_in;

  dioc_pattern_gen u_gen (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .pat(pat_bus.gen)
  );

  // Register writes, read data, trigger edges and the burst sequencer.
  always_comb begin
    logic wedge;
    logic redge;
    logic start_w;
    logic start_r;
    wedge = 1'b0;
    redge = 1'b0;
    start_w = (st_ff.state == DIOC_IDLE) && st_ff.wpend;
    start_r = (st_ff.state == DIOC_IDLE) && !st_ff.wpend && st_ff.rpend;
    nxt_st = st_ff;
    if (cfg_wr_in) begin
      if (cfg_addr_in == `DIOC_OFS_CAL_LO) begin
        wedge = cfg_wdata_in[`DIOC_BIT_WTRIG] && !st_ff.regs.wtrig;
        redge = cfg_wdata_in[`DIOC_BIT_RTRIG] && !st_ff.regs.rtrig;
        nxt_st.regs.wtrig = cfg_wdata_in[`DIOC_BIT_WTRIG];
        nxt_st.regs.rtrig = cfg_wdata_in[`DIOC_BIT_RTRIG];
        nxt_st.regs.mask_sel = cfg_wdata_in[`DIOC_BIT_MASK];
        nxt_st.regs.cal_addr[3:0] = cfg_wdata_in[7:4];
      end else if (cfg_addr_in == `DIOC_OFS_CAL_HI) begin
        nxt_st.regs.cal_addr[11:4] = cfg_wdata_in;
      end else if (cfg_addr_in == `DIOC_OFS_PAT) begin
        nxt_st.regs.pat = cfg_wdata_in;
      end else if (cfg_addr_in == `DIOC_OFS_CLK) begin
        nxt_st.regs.pll_div = cfg_wdata_in[`DIOC_BIT_PLLDIV];
        nxt_st.regs.freq = cfg_wdata_in[3:0];
      end else if (cfg_addr_in == `DIOC_OFS_PH0) begin
        nxt_st.regs.ph0 = cfg_wdata_in[4:0];
      end else if (cfg_addr_in == `DIOC_OFS_PH1) begin
        nxt_st.regs.ph1 = cfg_wdata_in[4:0];
      end else if (cfg_addr_in == `DIOC_OFS_CS_LO) begin
        nxt_st.regs.ph_cs = cfg_wdata_in[4:0];
      end else if (cfg_addr_in == `DIOC_OFS_CMD_LO) begin
        nxt_st.regs.ph_cmd = cfg_wdata_in[4:0];
      end
    end
    // A new edge wins over the pending flag being consumed.
    nxt_st.wpend = (st_ff.wpend && !start_w) || wedge;
    nxt_st.rpend = (st_ff.rpend && !start_r) || redge;
    if (cfg_rd_in) begin
      if (cfg_addr_in == `DIOC_OFS_CAL_LO) begin
        nxt_st.rdata = {st_ff.regs.cal_addr[3:0], 1'b0, st_ff.regs.mask_sel,
                        st_ff.regs.wtrig, st_ff.regs.rtrig};
      end else if (cfg_addr_in == `DIOC_OFS_CAL_HI) begin
        nxt_st.rdata = st_ff.regs.cal_addr[11:4];
      end else if (cfg_addr_in == `DIOC_OFS_PAT) begin
        nxt_st.rdata = st_ff.regs.pat;
      end else if (cfg_addr_in == `DIOC_OFS_CLK) begin
        nxt_st.rdata = {2'b00, st_ff.regs.pll_div, 1'b0, st_ff.regs.freq};
      end else if (cfg_addr_in == `DIOC_OFS_PH0) begin
        nxt_st.rdata = {3'b000, st_ff.regs.ph0};
      end else if (cfg_addr_in == `DIOC_OFS_PH1) begin
        nxt_st.rdata = {3'b000, st_ff.regs.ph1};
      end else if (cfg_addr_in == `DIOC_OFS_CS_LO) begin
        nxt_st.rdata = {3'b000, st_ff.regs.ph_cs};
      end else if (cfg_addr_in == `DIOC_OFS_CMD_LO) begin
        nxt_st.rdata = {3'b000, st_ff.regs.ph_cmd};
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end
    case (st_ff.state)
      DIOC_IDLE: begin
        if (start_w) begin
          nxt_st.is_wr = 1'b1;
          nxt_st.burst = 3'h0;
          nxt_st.state = DIOC_REQ;
        end else if (start_r) begin
          nxt_st.is_wr = 1'b0;
          nxt_st.burst = 3'h0;
          nxt_st.mismatch = 1'b0;
          nxt_st.state = DIOC_REQ;
        end
      end
      DIOC_REQ: begin
        if (cal_req_ready_in) begin
          nxt_st.beat = 3'h0;
          nxt_st.state = st_ff.is_wr ? DIOC_WBEAT : DIOC_RBEAT;
        end
      end
      default: begin
        if (rd_beat_take && (cal_rdata_in != pat_bus.qw)) begin
          nxt_st.mismatch = 1'b1;
        end
        if (wr_beat_take || rd_beat_take) begin
          if (st_ff.beat != `DIOC_LAST_IDX) begin
            nxt_st.beat = st_ff.beat + 3'h1;
          end else if (st_ff.burst != `DIOC_LAST_IDX) begin
            nxt_st.burst = st_ff.burst + 3'h1;
            nxt_st.state = DIOC_REQ;
          end else begin
            nxt_st.state = DIOC_IDLE;
          end
        end
      end
    endcase
  end

  // The whole control state is registered at once.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Request, data and status outputs of the calibration engine.
  assign cfg_rdata_out = st_ff.rdata;
  assign cal_req_valid_out = (st_ff.state == DIOC_REQ);
  assign cal_req_write_out = st_ff.is_wr;
  assign cal_req_addr_out = {st_ff.regs.cal_addr, 11'h000, st_ff.burst, 6'h00};
  assign cal_wvalid_out = (st_ff.state == DIOC_WBEAT);
  assign cal_wdata_out = pat_bus.qw;
  assign byte_mask_out = (cal_wvalid_out && st_ff.regs.mask_sel && st_ff.beat[0]) ?
                         `DIOC_MASK_ALL : `DIOC_MASK_NONE;
  assign cal_busy_out = (st_ff.state != DIOC_IDLE);
  assign cal_mismatch_out = st_ff.mismatch;

  // PLL control: the reset code stops the PLL, other codes outside 4-7 are flagged.
  assign pll_freq_code_out = st_ff.regs.freq;
  assign pll_reset_out = (st_ff.regs.freq == `DIOC_FREQ_PLL_RST);
  assign freq_illegal_out = !pll_reset_out && ((st_ff.regs.freq < `DIOC_FREQ_MIN) ||
                            (st_ff.regs.freq > `DIOC_FREQ_MAX));
  assign pll_vco_div2_out = !st_ff.regs.pll_div;

  // Memory clock pairs of module 0.
  dioc_phase_delay #(.W(3)) u_mclk0 (
    .mclk_in(mclk_in), .rst_in(rst_in), .d_in({3{mclk_run_in}}),
    .phase_in(st_ff.regs.ph0), .q_out(memory_clock_out[2:0]), .tap_out(mclk0_tap_out)
  );

  // Memory clock pairs of module 1.
  dioc_phase_delay #(.W(3)) u_mclk1 (
    .mclk_in(mclk_in), .rst_in(rst_in), .d_in({3{mclk_run_in}}),
    .phase_in(st_ff.regs.ph1), .q_out(memory_clock_out[5:3]), .tap_out(mclk1_tap_out)
  );

  // Rank selects idle high, clock enables idle low.
  dioc_phase_delay #(.W(8), .RST_VAL(8'hf0)) u_rank (
    .mclk_in(mclk_in), .rst_in(rst_in), .d_in({core_rank_select_n_in, core_cke_in}),
    .phase_in(st_ff.regs.ph_cs), .q_out({rank_select_n_out, rank_clock_enable_out}),
    .tap_out(rank_tap_out)
  );

  // Command strobes idle high, address and bank idle low.
  dioc_phase_delay #(.W(22), .RST_VAL(22'h38_0000)) u_cmd (
    .mclk_in(mclk_in), .rst_in(rst_in),
    .d_in({core_row_strobe_n_in, core_column_strobe_n_in, core_write_enable_n_in,
           core_address_in, core_bank_in}),
    .phase_in(st_ff.regs.ph_cmd),
    .q_out({row_strobe_n_out, column_strobe_n_out, write_enable_n_out,
            memory_address_out, bank_address_out}),
    .tap_out(cmd_tap_out)
  );

  // Counts accepted bursts of the running sequence for checking.
  logic [3:0] acc_cnt_ff;
  always_ff @(posedge mclk_in) begin
    if (rst_in || !cal_busy_out) begin
      acc_cnt_ff <= 4'h0;
    end else if (cal_req_valid_out && cal_req_ready_in) begin
      acc_cnt_ff <= acc_cnt_ff + 4'h1;
    end
  end

  default clocking dioc_cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  AST_FIRST_ADDR: assert property ($rose(cal_busy_out) |->
    cal_req_addr_out == {st_ff.regs.cal_addr, `DIOC_ZERO_LOW})
    else $error("First burst address wrong.");
  AST_EIGHT_BURSTS: assert property ($fell(cal_busy_out) |->
    $past(acc_cnt_ff) == `DIOC_BURSTS)
    else $error("Sequence did not issue eight bursts.");
  AST_WRITE_START: assert property ((st_ff.state == DIOC_IDLE && st_ff.wpend) |=>
    cal_req_valid_out && cal_req_write_out)
    else $error("Write trigger did not start a write burst.");
  AST_ODD_INVERT: assert property (cal_wvalid_out |->
    cal_wdata_out[15:8] == ~cal_wdata_out[7:0])
    else $error("Odd byte is not the inverse.");
  AST_SHIFT_CHAIN: assert property ((wr_beat_take && st_ff.beat != `DIOC_LAST_IDX) ##1
    cal_wvalid_out |-> cal_wdata_out[7:0] == ($past(cal_wdata_out[55:48]) >> 1))
    else $error("Even byte chain broken across quadwords.");
  AST_ZERO_FILL: assert property (cal_wvalid_out |-> !cal_wdata_out[23])
    else $error("Shifted byte did not fill zero.");
  AST_NO_RETRIG: assert property (($fell(cal_busy_out) && !st_ff.wpend &&
    !st_ff.rpend && !cfg_wr_in) |=> !cal_busy_out [*2])
    else $error("Sequence restarted without a new edge.");
  AST_MASK_OFF: assert property ((cal_wvalid_out && !st_ff.regs.mask_sel) |->
    byte_mask_out == `DIOC_MASK_NONE)
    else $error("Mask asserted while masking is off.");
  AST_MASK_ALT: assert property ((wr_beat_take && st_ff.regs.mask_sel &&
    st_ff.beat != `DIOC_LAST_IDX) |=> byte_mask_out == ~$past(byte_mask_out))
    else $error("Mask does not alternate.");
  AST_READ_MISS: assert property ((rd_beat_take && cal_rdata_in != pat_bus.qw) |=>
    cal_mismatch_out)
    else $error("Read mismatch not flagged.");
  AST_FIRST_BYTE: assert property ((cal_wvalid_out && st_ff.beat == 3'h0) |->
    cal_wdata_out[7:0] == st_ff.regs.pat)
    else $error("First byte is not the pattern register.");
  AST_LEVEL_PAT: assert property (($past(pat_bus.load) && $past(pat_bus.level_mode) &&
    $past(read_level_sel_in)) |-> pat_bus.qw == `DIOC_LVL_01)
    else $error("Leveling pattern wrong.");
  AST_PLL_RESET: assert property ((cfg_wr_in && cfg_addr_in == `DIOC_OFS_CLK &&
    cfg_wdata_in[3:0] == `DIOC_FREQ_PLL_RST) |=> pll_reset_out && !freq_illegal_out)
    else $error("PLL not held in reset.");
  AST_CMD_RETIME: assert property (!$past(rst_in) |->
    memory_address_out == $past(core_address_in) && cmd_tap_out == $past(st_ff.regs.ph_cmd))
    else $error("Command group not retimed with its tap.");

  COV_WRITE_SEQ: cover property (cal_busy_out && cal_req_write_out ##1 !cal_busy_out);
  COV_READ_MISS: cover property (rd_beat_take && cal_rdata_in != pat_bus.qw);
  COV_LEVEL_READ: cover property (rd_beat_take && pat_bus.level_mode);
  COV_PLL_RESET: cover property ($rose(pll_reset_out));

endmodule : dioc_top

// ### dv/dioc_mem_model.sv
`timescale 1ns/1ps
// Behavioural memory behind the calibration sequencer, prompt or slow.
module dioc_mem_model (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic corrupt_in,
  input wire logic [1:0] lvl_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [31:0] req_addr_in,
  output logic req_ready_out,
  input wire logic wvalid_in,
  input wire logic [63:0] wdata_in,
  output logic wready_out,
  output logic rvalid_out,
  output logic [63:0] rdata_out
);
  logic [63:0] mem [0:63];
  logic [63:0] src;
  logic [2:0] bsel_ff, wbeat_ff, rbeat_ff;
  logic rd_act_ff, tick_ff, go;

  // A slow memory accepts requests and beats only on every other cycle.
  assign go = tick_ff || !slow_in;
  assign req_ready_out = req_valid_in && go;
  assign wready_out = wvalid_in && go;

  // Read source is stored data or a fixed leveling answer, optionally with one bad bit.
  always_comb begin
    case (lvl_in)
      2'h1: src = 64'h0100_0100_0100_0100;
      2'h2: src = 64'hff00_ff00_ff00_ff00;
      default: src = mem[{bsel_ff, rbeat_ff}];
    endcase
    if (corrupt_in && rbeat_ff == 3'h3) begin
      src[0] = ~src[0];
    end
  end

  // Stores write beats and returns eight read beats, the first one cycle after a read request is taken, or two when slow.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      bsel_ff <= 3'h0;
      wbeat_ff <= 3'h0;
      rbeat_ff <= 3'h0;
      rd_act_ff <= 1'b0;
      tick_ff <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= 64'h0000_0000_0000_0000;
    end else begin
      tick_ff <= ~tick_ff;
      rvalid_out <= 1'b0;
      rdata_out <= ~rdata_out; // An idle data bus never holds its last value.
      if (wvalid_in && wready_out) begin
        mem[{bsel_ff, wbeat_ff}] <= wdata_in;
        wbeat_ff <= wbeat_ff + 3'h1;
      end
      if (rd_act_ff && go) begin
        rvalid_out <= 1'b1;
        rdata_out <= src;
        rbeat_ff <= rbeat_ff + 3'h1;
        rd_act_ff <= (rbeat_ff != 3'h7);
      end
      if (req_valid_in && req_ready_out) begin
        bsel_ff <= req_addr_in[8:6];
        wbeat_ff <= 3'h0;
        rbeat_ff <= 3'h0;
        rd_act_ff <= !req_write_in;
      end
    end
  end
endmodule : dioc_mem_model

// ### dv/tb_dram_io_calibration_and_clocking.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_dram_io_calibration_and_clocking;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] cfg_addr_in, cfg_wdata_in, cfg_rdata_out, byte_mask_out;
  logic cfg_wr_in, cfg_rd_in, cal_req_valid_out, cal_req_write_out, cal_req_ready_in;
  logic [31:0] cal_req_addr_out;
  logic cal_wvalid_out, cal_wready_in, cal_rvalid_in, read_level_mode_in, read_level_sel_in;
  logic [63:0] cal_wdata_out, cal_rdata_in;
  logic cal_busy_out, cal_mismatch_out, pll_reset_out, pll_vco_div2_out, freq_illegal_out;
  logic mclk_run_in, row_strobe_n_out, column_strobe_n_out, write_enable_n_out;
  logic [3:0] pll_freq_code_out, core_rank_select_n_in, core_cke_in;
  logic [3:0] rank_select_n_out, rank_clock_enable_out;
  logic core_row_strobe_n_in, core_column_strobe_n_in, core_write_enable_n_in;
  logic [15:0] core_address_in, memory_address_out;
  logic [2:0] core_bank_in, bank_address_out, bb;
  logic [5:0] memory_clock_out;
  logic [4:0] mclk0_tap_out, mclk1_tap_out, rank_tap_out, cmd_tap_out;
  logic slow, corrupt, t_sel, t_wr;
  logic [1:0] lvl;
  logic [7:0] t_seed;
  logic [11:0] t_cal;
  int mismatches = 0;
  int checked = 0;
  int nreq = 0;
  int nbeat = 0;
  int nreq0 = 0;
  int nbeat0 = 0;
  logic [7:0] ra [10] = '{8'h8e, 8'h8d, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h8f};
  logic [7:0] rx [10] = '{8'hff, 8'hff, 8'h2f, 8'h1f, 8'h1f, 8'h1f, 8'h00, 8'h1f, 8'h00, 8'h00};

  dioc_top dioc_top_inst (.*);
  dioc_mem_model dioc_mem_model_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .slow_in(slow), .corrupt_in(corrupt), .lvl_in(lvl),
    .req_valid_in(cal_req_valid_out), .req_write_in(cal_req_write_out),
    .req_addr_in(cal_req_addr_out), .req_ready_out(cal_req_ready_in),
    .wvalid_in(cal_wvalid_out), .wdata_in(cal_wdata_out), .wready_out(cal_wready_in),
    .rvalid_out(cal_rvalid_in), .rdata_out(cal_rdata_in)
  );

  // The 200 MHz core clock.
  always #2.5 mclk_in = ~mclk_in;

  // Expected write quadword: even bytes shift right with zero fill, odd bytes invert.
  function automatic logic [63:0] exp_qw(input logic [7:0] s, input logic [2:0] b);
    logic [63:0] q;
    int sh;
    q = 64'h0000_0000_0000_0000;
    for (int j = 0; j < 4; j++) begin
      sh = b * 4 + j;
      q[j*16 +: 8] = (sh > 7) ? 8'h00 : (s >> sh);
      q[j*16+8 +: 8] = ~q[j*16 +: 8];
    end
    return q;
  endfunction : exp_qw

  // Watches every burst request and write beat handed to the memory.
  // Sampled at the falling edge, where the handshake of the coming rising edge is settled.
  always @(negedge mclk_in) begin
    if (cal_req_valid_out && cal_req_ready_in) begin
      `CHK("req_addr", {t_cal, 20'h0_0000} + (nreq - nreq0) * 64, cal_req_addr_out)
      `CHK("req_write", t_wr, cal_req_write_out)
      nreq++;
      bb = 3'h0;
    end
    if (cal_wvalid_out && cal_wready_in) begin
      `CHK("wdata", exp_qw(t_seed, bb), cal_wdata_out)
      `CHK("byte_mask", (t_sel && bb[0]) ? 8'hff : 8'h00, byte_mask_out)
      bb = bb + 3'h1;
      nbeat++;
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // One register write on the configuration port.
  task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    cfg_addr_in <= a;
    cfg_wdata_in <= d;
    cfg_wr_in <= 1'b1;
    @(posedge mclk_in);
    cfg_wr_in <= 1'b0;
  endtask : cfg_wr

  // One register read, compared with the expected byte.
  task automatic check_rd(input logic [7:0] a, input logic [7:0] ex);
    @(posedge mclk_in);
    cfg_addr_in <= a;
    cfg_rd_in <= 1'b1;
    @(posedge mclk_in);
    cfg_rd_in <= 1'b0;
    #1;
    `CHK("cfg_rdata", ex, cfg_rdata_out)
  endtask : check_rd

  // Writes the control byte, then counts the bursts that follow.
  task automatic run_cal(input logic [7:0] ctl, input logic wr, input int bursts);
    int n;
    nreq0 = nreq;
    nbeat0 = nbeat;
    t_wr = wr;
    cfg_wr(8'h8c, ctl);
    #1;
    n = 0;
    while (cal_busy_out !== 1'b1 && n < 8) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    `CHK("busy", bursts > 0, cal_busy_out)
    n = 0;
    while (cal_busy_out === 1'b1 && n < 4000) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    if (n >= 4000) begin
      mismatches++;
      $display("[FAIL] busy expected 0 seen 1");
      complete_run();
    end
    @(posedge mclk_in);
    #1;
    `CHK("bursts", bursts, nreq - nreq0)
    `CHK("beats", wr ? bursts * 8 : 0, nbeat - nbeat0)
  endtask : run_cal

  // Main sequence of tests.
  initial begin
    {cfg_addr_in, cfg_wdata_in, cfg_wr_in, cfg_rd_in, read_level_mode_in} = '0;
    {read_level_sel_in, core_cke_in, core_address_in, core_bank_in, corrupt, lvl} = '0;
    {core_rank_select_n_in, core_row_strobe_n_in, core_column_strobe_n_in} = '1;
    {core_write_enable_n_in, mclk_run_in, slow} = 3'h7;
    {t_sel, t_wr, t_seed, t_cal} = '0;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      check_rd(ra[i], 8'h00);
      cfg_wr(ra[i], 8'hff);
      check_rd(ra[i], rx[i]);
    end
    $display("test registers done");
    for (int c = 0; c < 16; c++) begin
      cfg_wr(8'h90, 8'h0f);
      #1;
      `CHK("pll_reset", 1'b1, pll_reset_out)
      repeat (2) @(posedge mclk_in);
      cfg_wr(8'h90, {2'h0, c[0], 1'b0, c[3:0]});
      @(posedge mclk_in);
      #1;
      `CHK("freq_code", c[3:0], pll_freq_code_out)
      `CHK("pll_reset", c == 15, pll_reset_out)
      `CHK("illegal", !((c >= 4 && c <= 7) || c == 15), freq_illegal_out)
      `CHK("vco_div2", !c[0], pll_vco_div2_out)
    end
    $display("test clock frequency done");
    cfg_wr(8'h91, 8'h05);
    cfg_wr(8'h92, 8'h1a);
    cfg_wr(8'h93, 8'h11);
    cfg_wr(8'h95, 8'h1f);
    @(posedge mclk_in);
    core_rank_select_n_in <= 4'h5;
    core_cke_in <= 4'ha;
    {core_row_strobe_n_in, core_column_strobe_n_in, core_write_enable_n_in} <= 3'h2;
    core_address_in <= 16'hbeef;
    core_bank_in <= 3'h6;
    @(posedge mclk_in);
    #1;
    `CHK("taps0", 5'h05, mclk0_tap_out)
    `CHK("taps1", 5'h1a, mclk1_tap_out)
    `CHK("clock_run", 6'h3f, memory_clock_out)
    `CHK("rank_tap", 5'h11, rank_tap_out)
    `CHK("rank", {4'h5, 4'ha}, {rank_select_n_out, rank_clock_enable_out})
    `CHK("cmd_tap", 5'h1f, cmd_tap_out)
    `CHK("strobes", 3'h2, {row_strobe_n_out, column_strobe_n_out, write_enable_n_out})
    `CHK("addr_bank", {16'hbeef, 3'h6}, {memory_address_out, bank_address_out})
    $display("test phase groups done");
    cfg_wr(8'h8e, 8'h5a);
    cfg_wr(8'h8d, 8'h12);
    t_seed = 8'h5a;
    t_cal = 12'h123;
    run_cal(8'h32, 1'b1, 8);
    t_sel = 1'b1;
    run_cal(8'h36, 1'b1, 0);
    check_rd(8'h8c, 8'h36);
    run_cal(8'h34, 1'b1, 0);
    cfg_wr(8'h8e, 8'h81);
    t_seed = 8'h81;
    slow <= 1'b0;
    run_cal(8'h36, 1'b1, 8);
    $display("test calibration write done");
    run_cal(8'h31, 1'b0, 8);
    `CHK("mismatch", 1'b0, cal_mismatch_out)
    corrupt <= 1'b1;
    run_cal(8'h30, 1'b0, 0);
    run_cal(8'h31, 1'b0, 8);
    `CHK("mismatch", 1'b1, cal_mismatch_out)
    corrupt <= 1'b0;
    $display("test calibration read done");
    cfg_wr(8'h8e, 8'h00);
    read_level_mode_in <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk_in);
      read_level_sel_in <= !k[0];
      lvl <= k[1] ? 2'h2 - k[0] : 2'h1 + k[0];
      run_cal(8'h30, 1'b0, 0);
      run_cal(8'h31, 1'b0, 8);
      `CHK("level_mismatch", k == 2 || k == 3, cal_mismatch_out)
    end
    $display("test read leveling done");
    complete_run();
  end
endmodule : tb_dram_io_calibration_and_clocking
